/* bench/bbc_cap_model.sv */
// Extension capacitor on the blank extension pin, seen through its two comparators.
// Assumes the block drives the charge and discharge switches from clk.
`timescale 1ns/100ps
`default_nettype none

module bbc_cap_model #(
	parameter int TOP = 8
) (
	// Clock and switches.
	input  wire logic clk,
	input  wire logic chargeOn,
	input  wire logic dischargeOn,
	// Comparator outputs.
	output logic      capHigh,
	output logic      capLow
);
	int lvl = 0;

	// The pin ramps while a switch is closed and holds its charge otherwise.
	always @(posedge clk) begin
		if (chargeOn && lvl < TOP)
			lvl <= lvl + 1;
		else if (dischargeOn && lvl > 0)
			lvl <= lvl - 1;
	end

	// Upper and lower trip points; a larger TOP makes a slower capacitor.
	assign capHigh = (lvl >= TOP);
	assign capLow  = (lvl == 0);
endmodule // bbc_cap_model
`default_nettype wire

/* bench/tb_burst_and_blanking_control.sv */
// Self-checking bench of the burst and blanking control block.
// Assumes the capacitor model on the extension pin and a fast oscillator tick.
`timescale 1ns/100ps
`default_nettype none
`define TB_CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; $display("Error %s expected %0h seen %0h", nm, e, g); end end

module tb_burst_and_blanking_control;
	logic clk = 0, arst_n = 0, oscTick = 0, gateOn = 0, supplyOn = 0, protectionActive = 1;
	logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, capHigh, capLow;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pwmOff, blankActive, biasEnable, burstFlag, detDischarge, extCharge, extDischarge, restartReq;
	bbc_pkg::bbc_cmp_t drv = '0, cmpIn;
	bbc_pkg::bbc_limit_t limitSel;
	int miscompares = 0, checks = 0, n, tc = 0;

	// Capacitor comparators come from the partner, the rest from the bench.
	always_comb begin
		cmpIn = drv;
		cmpIn.capAbove4v5 = capHigh;
		cmpIn.capBelow0v9 = capLow;
	end

	bbc_control dut (.clk(clk), .arst_n(arst_n), .cmp(cmpIn), .oscTick(oscTick), .gateOn(gateOn),
		.supplyOn(supplyOn), .protectionActive(protectionActive), .pwmOff(pwmOff),
		.blankActive(blankActive), .biasEnable(biasEnable), .burstFlag(burstFlag),
		.limitSel(limitSel), .detDischarge(detDischarge), .extCharge(extCharge),
		.extDischarge(extDischarge), .restartReq(restartReq), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	bbc_cap_model capm (.clk(clk), .chargeOn(extCharge), .dischargeOn(extDischarge),
		.capHigh(capHigh), .capLow(capLow));

	// Clock and a one-cycle oscillator tick every fourth cycle.
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) begin
		tc <= (tc + 1) % 4;
		oscTick <= (tc == 3);
	end

	// One APB transfer; read data and error are taken at the pready edge.
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
	endtask

	task tally_and_finish;
		if (miscompares == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Control register masking and an unmapped address.
	task t_regs;
		`TB_CHK("limitSel", 4'hb, limitSel)
		`TB_CHK("biasEnable", 1'b1, biasEnable)
		apb(1, 12'h000, 32'hffffffff); apb(0, 12'h000, 0);
		`TB_CHK("ctrl", 32'h33, rd)
		apb(1, 12'h000, 32'h0); apb(0, 12'h010, 0);
		`TB_CHK("pslverr", 1'b1, err)
	endtask

	// Level detection: held by protection, then 20 feedback pulses give level 1.
	task t_detect;
		supplyOn <= 1;
		repeat (500) @(posedge clk);
		apb(0, 12'h004, 0);
		`TB_CHK("detDone held", 1'b0, rd[2])
		protectionActive <= 0;
		repeat (20) begin
			drv.fbAbove4v5 <= 1; @(posedge clk); drv.fbAbove4v5 <= 0; repeat (2) @(posedge clk);
			`TB_CHK("detDischarge set", 1'b1, detDischarge)
			drv.fbBelow0v5 <= 1; @(posedge clk); drv.fbBelow0v5 <= 0; repeat (2) @(posedge clk);
			`TB_CHK("detDischarge clr", 1'b0, detDischarge)
		end
		repeat (500) @(posedge clk);
		apb(0, 12'h008, 0);
		`TB_CHK("detCount", 32'd20, rd)
		`TB_CHK("level", 2'd1, limitSel.level)
	endtask

	// Current trip held from turn-on: ignored for the blanking span only.
	task t_blank(input int cyc);
		gateOn <= 1; drv.csTrip <= 1;
		repeat (cyc) @(posedge clk);
		`TB_CHK("pwmOff blanked", 1'b0, pwmOff)
		`TB_CHK("blankActive on", 1'b1, blankActive)
		repeat (3) @(posedge clk);
		`TB_CHK("pwmOff trip", 1'b1, pwmOff)
		`TB_CHK("blankActive off", 1'b0, blankActive)
		gateOn <= 0; drv.csTrip <= 0; repeat (2) @(posedge clk);
	endtask

	// Burst entry after an interrupted run, bias hysteresis and exit.
	task t_burst;
		drv.fbBelowEntry <= 1; repeat (6000) @(posedge clk);
		drv.fbBelowEntry <= 0; repeat (8) @(posedge clk);
		drv.fbBelowEntry <= 1; repeat (7960) @(posedge clk);
		`TB_CHK("burst early", 1'b0, burstFlag)
		for (n = 0; n < 400 && burstFlag !== 1'b1; n++) @(posedge clk);
		@(posedge clk);
		`TB_CHK("burstFlag", 1'b1, burstFlag)
		`TB_CHK("bias off", 1'b0, biasEnable)
		`TB_CHK("burstLimit", 2'b11, {limitSel.compEnable, limitSel.burstLimit})
		drv.fbBelowEntry <= 0; drv.fbAbove3v5 <= 1; repeat (2) @(posedge clk);
		`TB_CHK("bias wake", 1'b1, biasEnable)
		t_blank(36);
		drv.fbAbove3v5 <= 0; drv.fbBelow3v2 <= 1; repeat (2) @(posedge clk);
		`TB_CHK("bias sleep", 1'b0, biasEnable)
		drv.fbBelow3v2 <= 0; drv.fbAbove4v0 <= 1; repeat (2) @(posedge clk);
		`TB_CHK("burst exit", 2'b10, {limitSel.compEnable, limitSel.burstLimit})
		`TB_CHK("burstFlag exit", 1'b0, burstFlag)
		drv.fbAbove4v0 <= 0;
		apb(1, 12'h000, 32'h32); drv.fbBelowEntry <= 1; repeat (8800) @(posedge clk);
		`TB_CHK("level3 no burst", 1'b0, burstFlag)
		drv.fbBelowEntry <= 0; apb(1, 12'h000, 32'h1);
	endtask

	// Overload with extension: 20 ms, 256 capacitor cycles, 30 ms, restart.
	task t_overload;
		drv.fbAbove4v5 <= 1; repeat (7960) @(posedge clk);
		`TB_CHK("ext early", 1'b0, extCharge)
		for (n = 0; n < 400 && extCharge !== 1'b1; n++) @(posedge clk);
		`TB_CHK("extCharge", 1'b1, extCharge)
		`TB_CHK("restart blocked", 1'b0, restartReq)
		for (n = 0; n < 50 && extDischarge !== 1'b1; n++) @(posedge clk);
		`TB_CHK("charge off", 1'b0, extCharge)
		for (n = 0; n < 20000 && restartReq !== 1'b1; n++) @(posedge clk);
		`TB_CHK("restartReq", 1'b1, restartReq)
		`TB_CHK("restart late", 1'b1, n >= 12000)
		`TB_CHK("ext stopped", 1'b0, extCharge)
		apb(0, 12'h00c, 0);
		`TB_CHK("extCount", 32'h100, rd)
	endtask

	// Reset, then the scenarios in order.
	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1;
		@(posedge clk);
		t_regs;
		t_detect;
		t_blank(44);
		t_burst;
		t_overload;
		tally_and_finish;
	end

	// Watchdog against a hang.
	initial begin
		repeat (80000) @(posedge clk);
		miscompares++;
		tally_and_finish;
	end
endmodule // tb_burst_and_blanking_control
`default_nettype wire

/* src/bbc_blank_timer.sv */
// Oscillator-tick blanking timer that expires after a fixed time of continuous request.
// Assumes tick is a one-cycle pulse from the switching oscillator.
`timescale 1ns/100ps
`default_nettype none
`include "bbc_regs.svh"

module bbc_blank_timer (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic arst_n,
	// Timing request.
	input  wire logic tick,
	input  wire logic run,
	output logic      expired
);

	logic [11:0] cnt_reg;
	logic [11:0] cntNext;

	// Next count.
	assign cntNext = cnt_reg + 12'h001;

	// The count is cleared whenever the request drops, so each occurrence times from zero.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 12'h000;
			expired <= 1'b0;
		end else if (!run) begin
			cnt_reg <= 12'h000;
			expired <= 1'b0;
		end else if (tick && !expired) begin
			cnt_reg <= cntNext;
			expired <= (cntNext == 12'(`BBC_BLANK_TICKS));
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	blank_clear_a: assert property (!run |=> cnt_reg == 12'h000 && !expired)
		else $error("Blanking timer kept its count after the request dropped.");
	blank_count_a: assert property ($rose(expired) |-> cnt_reg == 12'(`BBC_BLANK_TICKS))
		else $error("Blanking timer expired at the wrong count.");

endmodule // bbc_blank_timer
`default_nettype wire

/* src/bbc_control.sv */
// Burst and blanking control: edge blanking, limit selection, burst level detection,
// burst mode, overload blanking with extension, restart request and the APB register slave.
// Assumes synchronous comparator inputs, a one-cycle oscillator tick and arst_n tied to lockout.
//
// Behaviour
// - Ignore current trips for 220 ns after turn-on, 180 ns in burst mode.
// - Enable slope-dependent limit compensation so steeper current ends on-time earlier.
// - Keep that compensation enabled for the reduced burst current limit too.
// - Burst entry and overload need a 20 ms blanking interval first.
// - In extend mode, after 20 ms block restart, start counting, charge the pin.
// - At 4.5 V on the pin count up, stop charging, start discharging.
// - At 0.9 V on the pin stop discharging and charge again.
// - Repeat until the count reaches 256, then stop and flag completion.
// - With overload and completion both high, wait 30 ms then request restart.
// - Four burst levels with three entry thresholds and limits; level four never bursts.
// - One level setting never enters burst mode.
// - Detect the level only in the first 1 ms after first supply turn-on.
// - Hold detection off while a protection is active before first start.
// - Detection flip-flop sets and counts at 4.5 V, clears at 0.5 V.
// - At window end, classify the count and latch threshold and limit.
// - Burst timer held at zero normally, runs while feedback below entry threshold.
// - Entering burst sets the burst flag and switches the bias off.
// - In burst, feedback above 3.5 V re-enables bias and switching.
// - In burst, use the reduced burst current limit.
// - In burst, feedback down to 3.2 V switches the bias off again.
// - Feedback above 4.0 V leaves burst and restores the normal limit.
// - Overload timer starts when feedback exceeds 4.5 V; the code starts it only once level detection is done.
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "bbc_regs.svh"

module bbc_control (
	// Clock and reset.
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	// Analog side.
	input  wire bbc_pkg::bbc_cmp_t    cmp,
	input  wire logic                 oscTick,
	input  wire logic                 gateOn,
	input  wire logic                 supplyOn,
	input  wire logic                 protectionActive,
	// Power stage side.
	output logic                      pwmOff,
	output logic                      blankActive,
	output logic                      biasEnable,
	output logic                      burstFlag,
	output bbc_pkg::bbc_limit_t       limitSel,
	output logic                      detDischarge,
	output logic                      extCharge,
	output logic                      extDischarge,
	output logic                      restartReq,
	// APB slave.
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr
);

	// Classifies a detection count into a burst level.
	function automatic logic [1:0] classify(input logic [7:0] n);
		if (n <= `BBC_DET_LVL0_MAX) classify = 2'h0;
		else if (n <= `BBC_DET_LVL1_MAX) classify = 2'h1;
		else if (n <= `BBC_DET_LVL2_MAX) classify = 2'h2;
		else classify = 2'h3;
	endfunction

	// Registers and state.
	bbc_pkg::bbc_burst_state_t state_reg;
	bbc_pkg::bbc_burst_state_t state_next;
	logic [31:0] ctrl_reg;
	logic [5:0]  lebCnt_reg;
	logic        gatePrev_reg;
	logic [7:0]  detCnt_reg;
	logic [6:0]  detWin_reg;
	logic        detDone_reg;
	logic [1:0]  level_reg;
	logic [11:0] spikeCnt_reg;
	logic        spikeDone_reg;

	// Decode wires.
	logic        gateEdge;
	logic        inBurst;
	logic        detActive;
	logic        windowEnd;
	logic [1:0]  levelUsed;
	logic        burstAllowed;
	logic        entryRun;
	logic        entryDone;
	logic        overloadRun;
	logic        overloadDone;
	logic        extendOn;
	logic        extDone;
	logic [8:0]  extCount;
	logic        restartGate;
	logic [11:0] spikeNext;
	logic        access;
	logic        writeNow;
	logic [31:0] readData;
	logic        addrHit;
	logic [31:0] statusWord;

	// Turn-on edge and mode decode.
	assign gateEdge  = gateOn && !gatePrev_reg;
	assign inBurst   = (state_reg != bbc_pkg::BST_NORMAL);
	assign extendOn  = ctrl_reg[`BBC_CTRL_EXTEND_BIT];

	// Leading edge blanking counter and gated current trip.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			gatePrev_reg <= 1'b0;
			lebCnt_reg   <= 6'h00;
			pwmOff       <= 1'b0;
			blankActive  <= 1'b0;
		end else begin
			gatePrev_reg <= gateOn;
			if (gateEdge)
				lebCnt_reg <= inBurst ? 6'(`BBC_LEB_BURST_CYC) : 6'(`BBC_LEB_NORM_CYC);
			else if (lebCnt_reg != 6'h00)
				lebCnt_reg <= lebCnt_reg - 6'h01;
			blankActive  <= gateEdge || (lebCnt_reg > 6'h01);
			pwmOff       <= cmp.csTrip && gateOn && !gateEdge && (lebCnt_reg == 6'h00);
		end
	end

	// Burst level detection window, first supply turn-on only.
	assign detActive = supplyOn && !protectionActive && !detDone_reg;
	assign windowEnd = detActive && oscTick && (detWin_reg == 7'(`BBC_DET_TICKS - 1));

	// Detection flip-flop, discharge switch, count and final classification.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			detWin_reg   <= 7'h00;
			detCnt_reg   <= 8'h00;
			detDischarge <= 1'b0;
			detDone_reg  <= 1'b0;
			level_reg    <= 2'h3;
		end else if (detActive) begin
			if (oscTick) detWin_reg <= detWin_reg + 7'h01;
			if (cmp.fbAbove4v5 && !detDischarge) begin
				detDischarge <= 1'b1;
				if (detCnt_reg != 8'hff) detCnt_reg <= detCnt_reg + 8'h01;
			end else if (cmp.fbBelow0v5) begin
				detDischarge <= 1'b0;
			end
			if (windowEnd) begin
				detDone_reg  <= 1'b1;
				detDischarge <= 1'b0;
				level_reg    <= classify(detCnt_reg);
			end
		end
	end

	// Level in use: the detected one, or the software override.
	assign levelUsed    = ctrl_reg[`BBC_CTRL_OVR_BIT] ? ctrl_reg[`BBC_CTRL_LVL_LSB +: 2] : level_reg;
	assign burstAllowed = detDone_reg && (levelUsed != 2'h3);

	// Burst entry and overload blanking timers.
	assign entryRun    = (state_reg == bbc_pkg::BST_NORMAL) && burstAllowed && cmp.fbBelowEntry;
	assign overloadRun = detDone_reg && cmp.fbAbove4v5;

	bbc_blank_timer uEntryTimer (
		.clk     (clk),
		.arst_n  (arst_n),
		.tick    (oscTick),
		.run     (entryRun),
		.expired (entryDone)
	);

	bbc_blank_timer uOverloadTimer (
		.clk     (clk),
		.arst_n  (arst_n),
		.tick    (oscTick),
		.run     (overloadRun),
		.expired (overloadDone)
	);

	// Extension oscillator runs only in extend mode after the basic interval.
	bbc_ext_counter uExtCounter (
		.clk         (clk),
		.arst_n      (arst_n),
		.start       (overloadDone && extendOn),
		.capHigh     (cmp.capAbove4v5),
		.capLow      (cmp.capBelow0v9),
		.chargeOn    (extCharge),
		.dischargeOn (extDischarge),
		.done        (extDone),
		.count       (extCount)
	);

	// Restart gate: extend mode waits for the extension count as well.
	assign restartGate = overloadRun && overloadDone && (!extendOn || extDone);
	assign spikeNext   = spikeCnt_reg + 12'h001;

	// Spike blanking before the restart request; the request holds until lockout resets it.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			spikeCnt_reg  <= 12'h000;
			spikeDone_reg <= 1'b0;
			restartReq    <= 1'b0;
		end else begin
			if (!restartGate) begin
				spikeCnt_reg  <= 12'h000;
				spikeDone_reg <= 1'b0;
			end else if (oscTick && !spikeDone_reg) begin
				spikeCnt_reg  <= spikeNext;
				spikeDone_reg <= (spikeNext == 12'(`BBC_SPIKE_TICKS));
			end
			if (restartGate && spikeDone_reg) restartReq <= 1'b1;
		end
	end

	// Burst mode sequence; leaving on 4.0 V has priority over the bias hysteresis.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			bbc_pkg::BST_NORMAL: begin
				if (entryDone && entryRun) state_next = bbc_pkg::BST_SLEEP;
			end
			bbc_pkg::BST_SLEEP: begin
				if (cmp.fbAbove4v0) state_next = bbc_pkg::BST_NORMAL;
				else if (cmp.fbAbove3v5) state_next = bbc_pkg::BST_WAKE;
			end
			bbc_pkg::BST_WAKE: begin
				if (cmp.fbAbove4v0) state_next = bbc_pkg::BST_NORMAL;
				else if (cmp.fbBelow3v2) state_next = bbc_pkg::BST_SLEEP;
			end
			default: state_next = bbc_pkg::BST_NORMAL;
		endcase
	end

	// Burst state, bias, flag and limit selection.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg  <= bbc_pkg::BST_NORMAL;
			biasEnable <= 1'b1;
			burstFlag  <= 1'b0;
			limitSel   <= '{compEnable: 1'b1, burstLimit: 1'b0, level: 2'h3};
		end else begin
			state_reg           <= state_next;
			biasEnable          <= (state_next != bbc_pkg::BST_SLEEP);
			burstFlag           <= (state_next != bbc_pkg::BST_NORMAL);
			limitSel.compEnable <= 1'b1;
			limitSel.burstLimit <= (state_next != bbc_pkg::BST_NORMAL);
			limitSel.level      <= levelUsed;
		end
	end

	// APB decode: the answer comes one cycle into the access phase.
	assign access   = psel && penable && !pready;
	assign writeNow = psel && penable && pready && pwrite && !pslverr;
	assign addrHit  = (paddr == `BBC_REG_CTRL) || (paddr == `BBC_REG_STATUS)
		|| (paddr == `BBC_REG_DETCNT) || (paddr == `BBC_REG_EXTCNT);

	// Status word of the block.
	assign statusWord = {23'h000000, restartReq, extDone, overloadRun && !overloadDone,
		levelUsed, 1'b0, detDone_reg, biasEnable, burstFlag};

	// Read selection.
	assign readData = (paddr == `BBC_REG_CTRL)   ? ctrl_reg :
		(paddr == `BBC_REG_STATUS) ? statusWord :
		(paddr == `BBC_REG_DETCNT) ? {24'h000000, detCnt_reg} :
		(paddr == `BBC_REG_EXTCNT) ? {23'h000000, extCount} : 32'h0000_0000;

	// APB answer registers and control register write.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= 32'h0000_0000;
			ctrl_reg <= `BBC_CTRL_RESET;
		end else begin
			pready  <= access;
			pslverr <= access && !addrHit;
			prdata  <= (access && !pwrite) ? readData : 32'h0000_0000;
			if (writeNow && paddr == `BBC_REG_CTRL)
				ctrl_reg <= pwdata & 32'h0000_0033;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	leb_load_a: assert property (gateEdge && !inBurst |=> lebCnt_reg == 6'(`BBC_LEB_NORM_CYC))
		else $error("Normal blanking loaded the wrong length.");
	leb_burst_a: assert property (gateEdge && inBurst |=> lebCnt_reg == 6'(`BBC_LEB_BURST_CYC))
		else $error("Burst blanking loaded the wrong length.");
	leb_mask_a: assert property (lebCnt_reg != 6'h00 |=> !pwmOff)
		else $error("Current trip passed during blanking.");
	det_once_a: assert property (detDone_reg |=> $stable(detCnt_reg) && $stable(level_reg))
		else $error("Level detection ran after the first window.");
	det_hold_a: assert property (protectionActive |=> $stable(detWin_reg))
		else $error("Detection window advanced under protection.");
	never_burst_a: assert property (levelUsed == 2'h3 && !inBurst |=> !inBurst)
		else $error("Burst entered at the never-burst level.");
	burst_entry_a: assert property (state_reg == bbc_pkg::BST_NORMAL && entryDone && entryRun
		|=> burstFlag && !biasEnable && limitSel.burstLimit)
		else $error("Burst entry did not set flag and cut bias.");
	bias_wake_a: assert property (state_reg == bbc_pkg::BST_SLEEP && cmp.fbAbove3v5
		&& !cmp.fbAbove4v0 |=> biasEnable && burstFlag)
		else $error("Bias not restored above the wake level.");
	bias_sleep_a: assert property (state_reg == bbc_pkg::BST_WAKE && cmp.fbBelow3v2
		&& !cmp.fbAbove4v0 |=> !biasEnable)
		else $error("Bias not cut at the sleep level.");
	burst_exit_a: assert property (inBurst && cmp.fbAbove4v0
		|=> !burstFlag && !limitSel.burstLimit && biasEnable)
		else $error("Burst not left above the exit level.");
	restart_cause_a: assert property ($rose(restartReq) |-> $past(restartGate)
		&& $past(spikeCnt_reg) == 12'(`BBC_SPIKE_TICKS))
		else $error("Restart requested without the spike interval.");
	spike_clear_a: assert property (!restartGate |=> spikeCnt_reg == 12'h000 && !spikeDone_reg)
		else $error("Spike blanking kept its count after the gate closed.");

	// Detection steps: a rise sets and counts, a fall clears, the window end latches.
	sequence detRiseS;
		detActive && !windowEnd && cmp.fbAbove4v5 && !detDischarge;
	endsequence
	sequence detFallS;
		detActive && !windowEnd && detDischarge && cmp.fbBelow0v5;
	endsequence
	det_set_a: assert property (detRiseS |=> detDischarge
		&& (detCnt_reg == 8'($past(detCnt_reg) + 8'h01) || detCnt_reg == 8'hff))
		else $error("Upper detection crossing did not set and count.");
	det_clear_a: assert property (detFallS |=> !detDischarge)
		else $error("Lower detection crossing did not clear the flip-flop.");
	det_end_a: assert property (windowEnd |=> detDone_reg && !detDischarge)
		else $error("Detection window end did not close the detection.");

	// Blanking flag, burst entry hold and restart blocking in extend mode.
	leb_flag_a: assert property (gateEdge |=> blankActive)
		else $error("Blanking flag missing after turn-on.");
	entry_hold_a: assert property (state_reg == bbc_pkg::BST_NORMAL && !entryRun
		|=> !burstFlag)
		else $error("Burst entered without a running entry timer.");
	restart_block_a: assert property (extendOn && !extDone && !restartReq |=> !restartReq)
		else $error("Restart requested before the extension count finished.");

endmodule // bbc_control
`default_nettype wire

/* src/bbc_ext_counter.sv */
// Extension oscillator: charges and discharges the extension capacitor and counts the cycles.
// Assumes the two capacitor comparators are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
`include "bbc_regs.svh"

module bbc_ext_counter (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Control and comparators.
	input  wire logic       start,
	input  wire logic       capHigh,
	input  wire logic       capLow,
	// Switches and result.
	output logic            chargeOn,
	output logic            dischargeOn,
	output logic            done,
	output logic [8:0]      count
);

	bbc_pkg::bbc_ext_state_t state_reg;
	bbc_pkg::bbc_ext_state_t state_next;
	logic                    hitHigh;
	logic                    lastCycle;

	// Decoded events.
	assign hitHigh   = (state_reg == bbc_pkg::EXT_CHARGE) && capHigh;
	assign lastCycle = (count == 9'(`BBC_EXT_CYCLES - 1));

	// Charge, discharge and finish sequence.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			bbc_pkg::EXT_IDLE: begin
				if (start) state_next = bbc_pkg::EXT_CHARGE;
			end
			bbc_pkg::EXT_CHARGE: begin
				if (capHigh) state_next = lastCycle ? bbc_pkg::EXT_DONE : bbc_pkg::EXT_DISCH;
			end
			bbc_pkg::EXT_DISCH: begin
				if (capLow) state_next = bbc_pkg::EXT_CHARGE;
			end
			bbc_pkg::EXT_DONE: state_next = bbc_pkg::EXT_DONE;
			default: state_next = bbc_pkg::EXT_IDLE;
		endcase
		if (!start) state_next = bbc_pkg::EXT_IDLE;
	end

	// State, switch drives and count; the switches follow the next state so they never overlap.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg   <= bbc_pkg::EXT_IDLE;
			chargeOn    <= 1'b0;
			dischargeOn <= 1'b0;
			done        <= 1'b0;
			count       <= 9'h000;
		end else begin
			state_reg   <= state_next;
			chargeOn    <= (state_next == bbc_pkg::EXT_CHARGE);
			dischargeOn <= (state_next == bbc_pkg::EXT_DISCH);
			done        <= (state_next == bbc_pkg::EXT_DONE);
			count       <= !start ? 9'h000 : (hitHigh ? count + 9'h001 : count);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence chargeHitS;
		start && hitHigh;
	endsequence
	sequence dischargeEndS;
		start && state_reg == bbc_pkg::EXT_DISCH && capLow;
	endsequence

	ext_start_a: assert property ($rose(start) && state_reg == bbc_pkg::EXT_IDLE |=> chargeOn)
		else $error("Extension start did not close the charge switch.");
	ext_increment_a: assert property (chargeHitS |=> count == 9'($past(count) + 9'h001)
		&& !chargeOn && (dischargeOn || done))
		else $error("Upper crossing did not count and swap switches.");
	ext_recharge_a: assert property (dischargeEndS |=> chargeOn && !dischargeOn)
		else $error("Lower crossing did not restart charging.");
	ext_finish_a: assert property (done |-> count == 9'(`BBC_EXT_CYCLES) && !chargeOn
		&& !dischargeOn)
		else $error("Extension completion without the full count.");

endmodule // bbc_ext_counter
`default_nettype wire

/* src/bbc_pkg.sv */
// Types of the burst and blanking control block.
// Assumes bbc_regs.svh holds every numeric constant.
package bbc_pkg;

	// Burst mode states, one-hot.
	typedef enum logic [2:0] {
		BST_NORMAL = 3'b001,
		BST_SLEEP  = 3'b010,
		BST_WAKE   = 3'b100
	} bbc_burst_state_t;

	// Extension oscillator states, one-hot.
	typedef enum logic [3:0] {
		EXT_IDLE   = 4'b0001,
		EXT_CHARGE = 4'b0010,
		EXT_DISCH  = 4'b0100,
		EXT_DONE   = 4'b1000
	} bbc_ext_state_t;

	// Comparator outputs from the analog front end.
	typedef struct packed {
		logic fbAbove4v5;
		logic fbBelow0v5;
		logic fbBelowEntry;
		logic fbAbove3v5;
		logic fbBelow3v2;
		logic fbAbove4v0;
		logic capAbove4v5;
		logic capBelow0v9;
		logic csTrip;
	} bbc_cmp_t;

	// Current limit selection towards the analog threshold generator.
	typedef struct packed {
		logic       compEnable;
		logic       burstLimit;
		logic [1:0] level;
	} bbc_limit_t;

endpackage

/* src/bbc_regs.svh */
// Constants of the burst and blanking control block: register map, fields, reset values, timing.
// Assumes a 200 MHz core clock and a one-cycle tick from the switching oscillator.
`ifndef BBC_REGS_SVH
`define BBC_REGS_SVH

// Register byte offsets on the APB slave.
`define BBC_REG_CTRL        12'h000
`define BBC_REG_STATUS      12'h004
`define BBC_REG_DETCNT      12'h008
`define BBC_REG_EXTCNT      12'h00c

// Control register fields and reset value.
`define BBC_CTRL_EXTEND_BIT 0
`define BBC_CTRL_OVR_BIT    1
`define BBC_CTRL_LVL_LSB    4
`define BBC_CTRL_RESET      32'h0000_0000

// Status register fields.
`define BBC_ST_BURST_BIT    0
`define BBC_ST_BIAS_BIT     1
`define BBC_ST_DETDONE_BIT  2
`define BBC_ST_LVL_LSB      4
`define BBC_ST_OVLD_BIT     6
`define BBC_ST_EXTDONE_BIT  7
`define BBC_ST_RESTART_BIT  8

// Core clock period and oscillator tick period in ns.
`define BBC_CLK_NS          5
`define BBC_OSC_NS          10000

// Edge blanking times in ns and their cycle counts, rounded up.
`define BBC_LEB_NORM_NS     220
`define BBC_LEB_BURST_NS    180
`define BBC_LEB_NORM_CYC    ((`BBC_LEB_NORM_NS + `BBC_CLK_NS - 1) / `BBC_CLK_NS)
`define BBC_LEB_BURST_CYC   ((`BBC_LEB_BURST_NS + `BBC_CLK_NS - 1) / `BBC_CLK_NS)

// Oscillator-timed windows in ms and their tick counts.
`define BBC_DET_MS          1
`define BBC_BLANK_MS        20
`define BBC_SPIKE_MS        30
`define BBC_DET_TICKS       (`BBC_DET_MS * 1000000 / `BBC_OSC_NS)
`define BBC_BLANK_TICKS     (`BBC_BLANK_MS * 1000000 / `BBC_OSC_NS)
`define BBC_SPIKE_TICKS     (`BBC_SPIKE_MS * 1000000 / `BBC_OSC_NS)

// Extension cycles before the extension counter reports completion.
`define BBC_EXT_CYCLES      256

// Highest detection count of each burst level; above the last is level 3.
`define BBC_DET_LVL0_MAX    8'h08
`define BBC_DET_LVL1_MAX    8'h28
`define BBC_DET_LVL2_MAX    8'ha0

`endif
